/* rtl/sas_pkg.sv */
package sas_pkg;
    // ------------------------------------------------------------
    // Clock and timebase
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 250_000_000;
    localparam int unsigned TB_BASE_HZ  = 1_000_000;
    localparam int unsigned TB_BASE_DIV = CLK_HZ / TB_BASE_HZ;
    localparam int unsigned PRE_W       = 8;
    localparam int unsigned DECADES     = 4;
    localparam logic [3:0]  DECADE_LAST = 4'h9;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] A_CMD1       = 4'h0;
    localparam logic [3:0] A_LIST_CLEAR = 4'h1;
    localparam logic [3:0] A_LIST_WRITE = 4'h2;
    localparam logic [3:0] A_LIST_FIRST = 4'h3;
    localparam logic [3:0] A_BUF_CLEAR  = 4'h4;
    localparam logic [3:0] A_START      = 4'h5;
    localparam logic [3:0] A_IVL_MODE   = 4'h6;
    localparam logic [3:0] A_IVL_LOAD   = 4'h7;
    localparam logic [3:0] A_SMP_LO     = 4'h8;
    localparam logic [3:0] A_SMP_HI     = 4'h9;
    localparam logic [3:0] A_SCAN_IVL   = 4'hA;
    localparam logic [3:0] A_STATUS     = 4'hB;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned B_ACQ_EN   = 0;
    localparam int unsigned B_SCAN_EN  = 1;
    localparam int unsigned B_SCAN_DIV = 2;
    localparam int unsigned B_WIDTH32  = 3;
    localparam int unsigned B_IVL_SCAN = 4;
    localparam int unsigned CMD1_W     = 5;
    localparam logic [4:0]  CMD1_RST   = 5'h00;
    localparam int unsigned EOS_BIT    = 15;
    localparam logic [15:0] LOAD_RST   = 16'h0002;
    localparam logic [16:0] FULL_COUNT = 17'h10000;

    // ------------------------------------------------------------
    // Interval counter mode words
    // ------------------------------------------------------------
    localparam logic [15:0] MODE_TB2  = 16'h8225;
    localparam logic [15:0] MODE_1M   = 16'h8B25;
    localparam logic [15:0] MODE_100K = 16'h8C25;
    localparam logic [15:0] MODE_10K  = 16'h8D25;
    localparam logic [15:0] MODE_1K   = 16'h8E25;
    localparam logic [15:0] MODE_100H = 16'h8F25;
    localparam logic [15:0] MODE_TB5  = 16'h8525;
    localparam logic [15:0] MODE_RST  = 16'h0000;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD} sas_state_t;
endpackage : sas_pkg

/* rtl/sas_sequencer.sv */
`timescale 1ns/1ps
module sas_sequencer #(
    parameter int unsigned LIST_DEPTH = 16,
    parameter int unsigned CG_W       = 8
) (
    input  wire logic                  clk_i,
    input  wire logic                  sys_rst_i,
    input  wire logic [3:0]            reg_addr_i,
    input  wire logic [15:0]           reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [15:0]           reg_rdata_o,
    input  wire logic                  ext_trig_n_i,
    input  wire logic                  timebase_input_two_i,
    input  wire logic                  timebase_input_five_i,
    input  wire logic                  divider_counter_output_i,
    output logic                       conv_n_o,
    output logic      [CG_W-1:0]       chan_gain_o,
    output logic                       end_of_sequence_flag_o,
    output logic                       acq_active_o,
    output logic                       conversion_buffer_clear_o
);
    localparam int unsigned PW = $clog2(LIST_DEPTH);

    generate
        if (LIST_DEPTH < 2 || CG_W > 15 || (1 << PW) != LIST_DEPTH) begin : g_chk
            $error("sas_sequencer: unsupported LIST_DEPTH or CG_W");
        end
    endgenerate

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] s1_ff, s2_ff, s3_ff;
    always_ff @(posedge clk_i) begin
        s1_ff <= {divider_counter_output_i, timebase_input_five_i,
                  timebase_input_two_i, ext_trig_n_i};
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
    end
    logic trig_fall, tb2_rise, tb5_rise, div_fall;
    assign trig_fall = s3_ff[0] & ~s2_ff[0];
    assign tb2_rise  = ~s3_ff[1] & s2_ff[1];
    assign tb5_rise  = ~s3_ff[2] & s2_ff[2];
    assign div_fall  = s3_ff[3] & ~s2_ff[3];

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    localparam int unsigned CMD1_W_L = sas_pkg::CMD1_W;
    logic [CMD1_W_L-1:0] cmd_ff, nxt_cmd;
    logic [15:0]         mode_ff, nxt_mode, ivl_ld_ff, nxt_ivl_ld, sivl_ff, nxt_sivl;
    logic [15:0]         rdata_ff, nxt_rdata;
    logic                bclr_ff, nxt_bclr;
    logic                w_clear, w_list, w_first, w_start;
    logic [PW-1:0]       wr_ptr_ff, scan_ptr_ff;
    logic                cnt_zero_ff;
    logic [15:0]         lo_ff, hi_ff;
    sas_pkg::sas_state_t st_ff;

    assign w_clear = reg_wr_i && reg_addr_i == sas_pkg::A_LIST_CLEAR;
    assign w_list  = reg_wr_i && reg_addr_i == sas_pkg::A_LIST_WRITE;
    assign w_first = reg_wr_i && reg_addr_i == sas_pkg::A_LIST_FIRST;
    assign w_start = reg_wr_i && reg_addr_i == sas_pkg::A_START;

    always_comb begin
        nxt_cmd   = cmd_ff;
        nxt_mode  = mode_ff;
        nxt_ivl_ld = ivl_ld_ff;
        nxt_sivl  = sivl_ff;
        nxt_bclr  = reg_wr_i && reg_addr_i == sas_pkg::A_BUF_CLEAR;
        nxt_rdata = rdata_ff;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                sas_pkg::A_CMD1:     nxt_cmd = reg_wdata_i[CMD1_W_L-1:0];
                sas_pkg::A_IVL_MODE: nxt_mode = reg_wdata_i;
                sas_pkg::A_IVL_LOAD: nxt_ivl_ld = reg_wdata_i;
                sas_pkg::A_SCAN_IVL: nxt_sivl = reg_wdata_i;
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                sas_pkg::A_CMD1:     nxt_rdata = 16'(cmd_ff);
                sas_pkg::A_IVL_MODE: nxt_rdata = mode_ff;
                sas_pkg::A_IVL_LOAD: nxt_rdata = ivl_ld_ff;
                sas_pkg::A_SMP_LO:   nxt_rdata = lo_ff;
                sas_pkg::A_SMP_HI:   nxt_rdata = hi_ff;
                sas_pkg::A_SCAN_IVL: nxt_rdata = sivl_ff;
                sas_pkg::A_STATUS:   nxt_rdata = 16'({scan_ptr_ff, wr_ptr_ff,
                                          cnt_zero_ff, st_ff == sas_pkg::ST_HOLD,
                                          st_ff != sas_pkg::ST_IDLE});
                default:             nxt_rdata = 16'h0000;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cmd_ff    <= sas_pkg::CMD1_RST;
            mode_ff   <= sas_pkg::MODE_RST;
            ivl_ld_ff <= sas_pkg::LOAD_RST;
            sivl_ff   <= sas_pkg::LOAD_RST;
            bclr_ff   <= 1'b0;
            rdata_ff  <= 16'h0000;
        end else begin
            cmd_ff    <= nxt_cmd;
            mode_ff   <= nxt_mode;
            ivl_ld_ff <= nxt_ivl_ld;
            sivl_ff   <= nxt_sivl;
            bclr_ff   <= nxt_bclr;
            rdata_ff  <= nxt_rdata;
        end
    end
    logic acq_en, scan_en, div_sel, wide, ivl_scan;
    assign acq_en   = cmd_ff[sas_pkg::B_ACQ_EN];
    assign scan_en  = cmd_ff[sas_pkg::B_SCAN_EN];
    assign div_sel  = cmd_ff[sas_pkg::B_SCAN_DIV];
    assign wide     = cmd_ff[sas_pkg::B_WIDTH32];
    assign ivl_scan = cmd_ff[sas_pkg::B_IVL_SCAN];

    // ------------------------------------------------------------
    // Timebase: 1 MHz prescaler then decade dividers
    // ------------------------------------------------------------
    localparam logic [sas_pkg::PRE_W-1:0] PRE_LAST =
        sas_pkg::PRE_W'(sas_pkg::TB_BASE_DIV - 1);
    logic [sas_pkg::PRE_W-1:0] pre_ff, nxt_pre;
    logic [sas_pkg::DECADES:0] tk;
    assign tk[0] = pre_ff == PRE_LAST;
    always_comb nxt_pre = tk[0] ? '0 : pre_ff + 1'b1;
    always_ff @(posedge clk_i) pre_ff <= sys_rst_i ? '0 : nxt_pre;

    genvar k;
    generate
        for (k = 0; k < sas_pkg::DECADES; k++) begin : g_dec
            logic [3:0] dec_ff, nxt_dec;
            assign tk[k+1] = tk[k] && dec_ff == sas_pkg::DECADE_LAST;
            always_comb nxt_dec = tk[k+1] ? 4'h0 : dec_ff + 4'(tk[k]);
            always_ff @(posedge clk_i) dec_ff <= sys_rst_i ? 4'h0 : nxt_dec;
        end
    endgenerate

    logic tb;
    always_comb begin
        unique case (mode_ff)
            sas_pkg::MODE_TB2:  tb = tb2_rise;
            sas_pkg::MODE_1M:   tb = tk[0];
            sas_pkg::MODE_100K: tb = tk[1];
            sas_pkg::MODE_10K:  tb = tk[2];
            sas_pkg::MODE_1K:   tb = tk[3];
            sas_pkg::MODE_100H: tb = tk[4];
            sas_pkg::MODE_TB5:  tb = tb5_rise;
            default:            tb = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Channel-gain list
    // ------------------------------------------------------------
    logic [CG_W:0]   mem [LIST_DEPTH];
    logic [CG_W-1:0] cg_ff;
    logic            eos_ff;
    logic [PW-1:0]   nxt_wr_ptr, nxt_scan_ptr;
    logic            fire, adv, scan_on, cur_eos;
    assign cur_eos = mem[scan_ptr_ff][CG_W];
    assign scan_on = scan_en && st_ff != sas_pkg::ST_IDLE;
    // Divider pulses only step the list, they never start a conversion
    assign adv = scan_on && (div_sel ? div_fall : fire);

    always_comb begin
        nxt_wr_ptr   = wr_ptr_ff + PW'(w_list);
        nxt_scan_ptr = scan_ptr_ff;
        if (adv) begin
            nxt_scan_ptr = cur_eos ? '0 : scan_ptr_ff + 1'b1;
        end
        if (w_first) begin
            nxt_scan_ptr = '0;
        end
        if (w_clear) begin
            nxt_wr_ptr   = '0;
            nxt_scan_ptr = '0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_ptr_ff   <= '0;
            scan_ptr_ff <= '0;
            cg_ff       <= '0;
            eos_ff      <= 1'b0;
        end else begin
            wr_ptr_ff   <= nxt_wr_ptr;
            scan_ptr_ff <= nxt_scan_ptr;
            cg_ff       <= mem[nxt_scan_ptr][CG_W-1:0];
            eos_ff      <= mem[nxt_scan_ptr][CG_W];
        end
    end
    // Storage array has no reset: software loads it before any scan
    always_ff @(posedge clk_i) begin
        if (w_list) begin
            mem[wr_ptr_ff] <= {reg_wdata_i[sas_pkg::EOS_BIT], reg_wdata_i[CG_W-1:0]};
        end
    end

    // ------------------------------------------------------------
    // Acquisition: interval, scan interval and sample counters
    // ------------------------------------------------------------
    sas_pkg::sas_state_t nxt_st;
    logic [16:0] ivl_ff, nxt_ivl, sc_ff, nxt_sc, n_eff, s_eff;
    logic [15:0] nxt_lo, nxt_hi;
    logic        nxt_cz, conv_n_ff, acq_ff, trig, last_cnt, done, pass_start;
    assign trig  = trig_fall || w_start;
    assign n_eff = ivl_ld_ff == 16'h0000 ? sas_pkg::FULL_COUNT : {1'b0, ivl_ld_ff};
    assign s_eff = sivl_ff == 16'h0000 ? sas_pkg::FULL_COUNT : {1'b0, sivl_ff};
    assign fire  = st_ff == sas_pkg::ST_RUN && tb && ivl_ff + 17'h1 == n_eff;
    assign pass_start = tb && sc_ff + 17'h1 == s_eff;
    // Wide mode ends when both halves are zero; narrow when lower hits zero
    assign last_cnt = wide ? (lo_ff == 16'h0000 && hi_ff == 16'h0000)
                           : lo_ff == 16'h0001;
    assign done = fire && (cnt_zero_ff || last_cnt)
                  && (!scan_en || cur_eos);

    always_comb begin
        nxt_st = st_ff;
        nxt_ivl = ivl_ff;
        nxt_sc  = pass_start ? 17'h0 : sc_ff + 17'(tb);
        nxt_lo  = lo_ff;
        nxt_hi  = hi_ff;
        nxt_cz  = cnt_zero_ff;
        if (reg_wr_i && reg_addr_i == sas_pkg::A_SMP_LO) begin
            nxt_lo = reg_wdata_i;
            nxt_cz = 1'b0;
        end
        if (reg_wr_i && reg_addr_i == sas_pkg::A_SMP_HI) begin
            nxt_hi = reg_wdata_i;
        end
        if (fire && !cnt_zero_ff) begin
            nxt_cz = last_cnt;
            nxt_lo = lo_ff - 16'h1;
            if (wide && lo_ff == 16'h0000) begin
                nxt_hi = hi_ff - 16'h1;
            end
        end
        if (st_ff == sas_pkg::ST_RUN && tb) begin
            nxt_ivl = fire ? 17'h0 : ivl_ff + 17'h1;
        end
        unique case (st_ff)
            sas_pkg::ST_IDLE: begin
                nxt_ivl = 17'h0;
                nxt_sc  = 17'h0;
                if (trig && acq_en) begin
                    nxt_st = sas_pkg::ST_RUN;
                end
            end
            sas_pkg::ST_RUN: begin
                if (done) begin
                    nxt_st = sas_pkg::ST_IDLE;
                end else if (fire && scan_en && cur_eos && ivl_scan) begin
                    nxt_st = sas_pkg::ST_HOLD;
                end
            end
            sas_pkg::ST_HOLD: begin
                nxt_ivl = 17'h0;
                if (pass_start) begin
                    nxt_st = sas_pkg::ST_RUN;
                end
            end
        endcase
        if (!acq_en) begin
            nxt_st = sas_pkg::ST_IDLE;
        end
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_ff       <= sas_pkg::ST_IDLE;
            ivl_ff      <= 17'h0;
            sc_ff       <= 17'h0;
            lo_ff       <= 16'h0000;
            hi_ff       <= 16'h0000;
            cnt_zero_ff <= 1'b0;
            conv_n_ff   <= 1'b1;
            acq_ff      <= 1'b0;
        end else begin
            st_ff       <= nxt_st;
            ivl_ff      <= nxt_ivl;
            sc_ff       <= nxt_sc;
            lo_ff       <= nxt_lo;
            hi_ff       <= nxt_hi;
            cnt_zero_ff <= nxt_cz;
            conv_n_ff   <= ~fire;
            acq_ff      <= nxt_st != sas_pkg::ST_IDLE;
        end
    end

    assign reg_rdata_o               = rdata_ff;
    assign conv_n_o                  = conv_n_ff;
    assign chan_gain_o               = cg_ff;
    assign end_of_sequence_flag_o    = eos_ff;
    assign acq_active_o              = acq_ff;
    assign conversion_buffer_clear_o = bclr_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_fire_last;
        fire && scan_en && cur_eos && !done;
    endsequence
    property p_cont_scan;
        @(posedge clk_i) disable iff (sys_rst_i)
        s_fire_last ##0 (!ivl_scan && acq_en) |=> st_ff == sas_pkg::ST_RUN;
    endproperty
    a_cont_scan: assert property (p_cont_scan) else $error("pass gap");
    property p_ivl_scan;
        @(posedge clk_i) disable iff (sys_rst_i)
        s_fire_last ##0 (ivl_scan && acq_en) |=> st_ff == sas_pkg::ST_HOLD;
    endproperty
    a_ivl_scan: assert property (p_ivl_scan) else $error("no hold");
    property p_single;
        @(posedge clk_i) disable iff (sys_rst_i)
        (!scan_en && !w_clear && !w_first) |=> $stable(scan_ptr_ff);
    endproperty
    a_single: assert property (p_single) else $error("ptr moved");
    property p_wrap;
        @(posedge clk_i) disable iff (sys_rst_i)
        adv && cur_eos |=> scan_ptr_ff == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");
    property p_step;
        @(posedge clk_i) disable iff (sys_rst_i)
        adv && !cur_eos && !w_clear && !w_first
        |=> scan_ptr_ff == $past(scan_ptr_ff) + 1'b1;
    endproperty
    a_step: assert property (p_step) else $error("bad step");
    property p_div;
        @(posedge clk_i) disable iff (sys_rst_i)
        div_sel && !div_fall && !w_clear && !w_first |=> $stable(scan_ptr_ff);
    endproperty
    a_div: assert property (p_div) else $error("div step");
    property p_clear;
        @(posedge clk_i) disable iff (sys_rst_i)
        w_clear |=> wr_ptr_ff == '0 && scan_ptr_ff == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear");
    property p_idle_quiet;
        @(posedge clk_i) disable iff (sys_rst_i)
        st_ff == sas_pkg::ST_IDLE |=> conv_n_o;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("idle pulse");
    property p_stop16;
        @(posedge clk_i) disable iff (sys_rst_i)
        fire && !wide && !scan_en && lo_ff == 16'h0001 |=> !acq_active_o;
    endproperty
    a_stop16: assert property (p_stop16) else $error("no stop");
    property p_pulse;
        @(posedge clk_i) disable iff (sys_rst_i)
        !conv_n_o |=> conv_n_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("long pulse");
    property p_start;
        @(posedge clk_i) disable iff (sys_rst_i)
        st_ff == sas_pkg::ST_IDLE && !acq_en |=> st_ff == sas_pkg::ST_IDLE;
    endproperty
    a_start: assert property (p_start) else $error("start");
endmodule : sas_sequencer

/* test/sas_far_side.sv */
`timescale 1ns/1ps
// ----
// Far side: source clock, trigger pin, divider output
// ----
module sas_far_side (
    output logic tb_five_o,
    output logic trig_n_o,
    output logic div_out_o
);
    initial begin
        tb_five_o = 1'b0;
        trig_n_o  = 1'b1;
        div_out_o = 1'b1;
    end

    // Runs free, phase unrelated to clk_i; rising edges are the ticks
    always #17 tb_five_o = ~tb_five_o;

    // Low pulse wide enough to clear the two-stage synchroniser
    task automatic pulse_trig;
        trig_n_o = 1'b0;
        #40;
        trig_n_o = 1'b1;
    endtask : pulse_trig

    // Low pulse on the divider output steps the list in divide mode
    task automatic pulse_div;
        div_out_o = 1'b0;
        #40;
        div_out_o = 1'b1;
    endtask : pulse_div
endmodule : sas_far_side

/* test/test_scanning_acquisition_sequencer.sv */
`timescale 1ns/1ps
module test_scanning_acquisition_sequencer;
    logic        clk_i;
    logic        sys_rst_i;
    logic [3:0]  reg_addr_i;
    logic [15:0] reg_wdata_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [15:0] reg_rdata_o;
    logic        trig_n;
    logic        tb_five;
    logic        div_out;
    logic        conv_n_o;
    logic [7:0]  chan_gain_o;
    logic        acq_active_o;
    logic        buf_clr;
    logic [7:0]  prev_cg;
    logic [7:0]  got[$];
    int          failures;
    int          checks_done;

    sas_sequencer sas_sequencer_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ext_trig_n_i(trig_n),
        .timebase_input_two_i(tb_five), .timebase_input_five_i(tb_five),
        .divider_counter_output_i(div_out), .conv_n_o(conv_n_o),
        .chan_gain_o(chan_gain_o), .end_of_sequence_flag_o(),
        .acq_active_o(acq_active_o), .conversion_buffer_clear_o(buf_clr));
    sas_far_side sas_far_side_i (.tb_five_o(tb_five), .trig_n_o(trig_n),
        .div_out_o(div_out));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Entry in force the cycle before each pulse, whatever the pointer does after
    always @(posedge clk_i) begin
        if (conv_n_o === 1'b0) got.push_back(prev_cg);
        prev_cg <= chan_gain_o;
    end

    // ----
    // Shared tasks
    // ----
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        #1 chk(nm, e, reg_rdata_o);
    endtask : rd

    task automatic load_list(input logic [15:0] ent[$]);
        wr(sas_pkg::A_LIST_CLEAR, 16'h0000);
        foreach (ent[i]) wr(sas_pkg::A_LIST_WRITE, ent[i]);
    endtask : load_list

    // Interval N=2 off the far-side source, then trigger and collect entries
    task automatic run(input logic [4:0] cmd, input logic [15:0] lo, input logic [15:0] hi,
                       input bit pin, input logic [7:0] exp[$]);
        int n;
        wr(sas_pkg::A_IVL_MODE, sas_pkg::MODE_TB5);
        wr(sas_pkg::A_IVL_LOAD, 16'h0002);
        wr(sas_pkg::A_SMP_LO, lo);
        wr(sas_pkg::A_SMP_HI, hi);
        wr(sas_pkg::A_BUF_CLEAR, 16'h0000);
        wr(sas_pkg::A_LIST_FIRST, 16'h0000);
        wr(sas_pkg::A_CMD1, {11'h000, cmd});
        got.delete();
        if (pin) sas_far_side_i.pulse_trig();
        else wr(sas_pkg::A_START, 16'h0000);
        n = 0;
        while (acq_active_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        chk("active", 16'h0001, {15'h0000, acq_active_o});
        n = 0;
        while (acq_active_o === 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        // Idle long enough for several intervals, so a late pulse would show
        repeat (80) @(posedge clk_i);
        chk("pulses", 16'(exp.size()), 16'(got.size()));
        foreach (exp[i]) chk("entry", {8'h00, exp[i]}, {8'h00, got[i]});
        wr(sas_pkg::A_CMD1, 16'h0000);
    endtask : run

    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        chk("conv_idle", 16'h0001, {15'h0000, conv_n_o});
        rd(sas_pkg::A_CMD1, 16'h0000, "cmd1");
        rd(sas_pkg::A_IVL_LOAD, sas_pkg::LOAD_RST, "ivl_load");
        rd(4'hC, 16'h0000, "unmapped");
    endtask : t_reset

    task automatic t_bufclr;
        wr(sas_pkg::A_BUF_CLEAR, 16'h0000);
        #1 chk("bufclr_hi", 16'h0001, {15'h0000, buf_clr});
        @(posedge clk_i);
        #1 chk("bufclr_lo", 16'h0000, {15'h0000, buf_clr});
    endtask : t_bufclr

    task automatic t_continuous;
        load_list('{16'h0011, 16'h0022, 16'h8033});
        run(5'h03, 16'h0006, 16'h0000, 1'b0, '{8'h11, 8'h22, 8'h33, 8'h11, 8'h22, 8'h33});
    endtask : t_continuous

    task automatic t_interval;
        wr(sas_pkg::A_SCAN_IVL, 16'h0010);
        run(5'h13, 16'h0006, 16'h0000, 1'b0, '{8'h11, 8'h22, 8'h33, 8'h11, 8'h22, 8'h33});
    endtask : t_interval

    task automatic t_single;
        run(5'h01, 16'h0003, 16'h0000, 1'b1, '{8'h11, 8'h11, 8'h11});
    endtask : t_single

    task automatic t_divide;
        // One divider pulse after the first conversion moves to the last entry
        load_list('{16'h0011, 16'h8022});
        fork
            run(5'h07, 16'h0003, 16'h0000, 1'b0, '{8'h11, 8'h22, 8'h22});
            begin
                @(negedge conv_n_o);
                sas_far_side_i.pulse_div();
            end
        join
    endtask : t_divide

    task automatic t_wide_reload;
        load_list('{16'h0044, 16'h8055});
        run(5'h0B, 16'h0003, 16'h0000, 1'b0, '{8'h44, 8'h55, 8'h44, 8'h55});
    endtask : t_wide_reload

    task automatic t_refused;
        wr(sas_pkg::A_CMD1, 16'h0002);
        got.delete();
        wr(sas_pkg::A_START, 16'h0000);
        repeat (80) @(posedge clk_i);
        chk("no_start", 16'h0000, {15'h0000, acq_active_o});
        chk("no_pulse", 16'h0000, 16'(got.size()));
    endtask : t_refused

    task automatic give_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    initial begin
        failures    = 0;
        checks_done = 0;
        sys_rst_i   = 1'b1;
        reg_addr_i  = 4'h0;
        reg_wdata_i = 16'h0000;
        reg_wr_i    = 1'b0;
        reg_rd_i    = 1'b0;
        prev_cg     = 8'h00;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_bufclr();
        t_continuous();
        t_interval();
        t_single();
        t_divide();
        t_wide_reload();
        t_refused();
        give_verdict();
    end

    // Runs take a few hundred cycles; 50000 means a hang
    initial begin
        #200000;
        failures++;
        give_verdict();
    end
endmodule : test_scanning_acquisition_sequencer
